/* rtl/icaux_pkg.sv */
// package of the interrupt controller auxiliary register block
// assumes a 32-bit apb slave port and 32 interrupt sources
package icaux_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ICAUX_OFF_VECTOR = 8'h00;
   localparam logic [7:0] ICAUX_OFF_FASTVEC = 8'h04;
   localparam logic [7:0] ICAUX_OFF_CUR_ID = 8'h08;
   localparam logic [7:0] ICAUX_OFF_PENDING = 8'h0C;
   localparam logic [7:0] ICAUX_OFF_ENABLE = 8'h10;
   localparam logic [7:0] ICAUX_OFF_DISABLE = 8'h14;
   localparam logic [7:0] ICAUX_OFF_MASKRD = 8'h18;
   localparam logic [7:0] ICAUX_OFF_EOI = 8'h1C;
   localparam logic [7:0] ICAUX_OFF_SPURIOUS = 8'h20;
   localparam logic [7:0] ICAUX_OFF_DEBUG = 8'h24;
   localparam logic [7:0] ICAUX_OFF_FF_EN = 8'h28;
   localparam logic [7:0] ICAUX_OFF_FF_DIS = 8'h2C;
   localparam logic [7:0] ICAUX_OFF_FF_STATE = 8'h30;
   localparam logic [7:0] ICAUX_OFF_IRQ_STAT = 8'h34;
   localparam logic [7:0] ICAUX_OFF_IRQ_MASK = 8'h38;
   localparam logic [7:0] ICAUX_OFF_VEC_BASE = 8'h80;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int ICAUX_PROTECTION_BIT = 0;
   localparam int ICAUX_LINE_MASK_BIT = 1;
   localparam int ICAUX_FAST_SRC = 0;
   localparam logic [31:0] ICAUX_SPUR_RESET = 32'h0000_0000;
   localparam logic [1:0] ICAUX_DEBUG_RESET = 2'h0;
   localparam logic [31:0] ICAUX_FF_RESET = 32'h0000_0000;
   // status bits: 0 end of interrupt seen, 1 spurious vector read
   localparam int ICAUX_EV_EOI = 0;
   localparam int ICAUX_EV_SPUR = 1;
   localparam int ICAUX_EVW = 2;

   typedef struct packed {
      logic sel;
      logic en;
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
   } icaux_req_s;

   typedef enum logic [0:0] {ICAUX_IDLE, ICAUX_BUSY} icaux_state_e;

endpackage : icaux_pkg

/* rtl/icaux_arb.sv */
// priority picker: lowest numbered requesting source wins
// assumes requests already masked; combinational only
module icaux_arb
   import icaux_pkg::*;
#(
   parameter int N = 32
) (
   // requests
   input wire logic [N-1:0] req,
   // result
   output logic any,
   output logic [4:0] id
);

   // scan from the top so the lowest index is the last to win
   always_comb begin
      any = 1'b0;
      id = 5'h0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            any = 1'b1;
            id = 5'(i);
         end
      end
   end

endmodule : icaux_arb

/* rtl/icaux_top.sv */
// interrupt controller tail: end of interrupt, spurious vector,
// debug control and fast forcing, behind an apb slave
// assumes level source inputs synchronous to clk
// Operation
// - any write to eoi ends current treatment
// - spurious vector register rw, resets zero
// - spurious case reads return spurious vector
// - debug bit 0 enables protection mode
// - debug bit 1 holds both lines inactive
// - fast enable write one sets forcing
// - fast disable write one clears forcing
// - fast state shows forcing per source
// - bit 0 reserved in forcing registers
// - vector read gives current source vector
//
// Our own choices: the register offsets and the APB interface to the registers.
module icaux_top
   import icaux_pkg::*;
#(
   parameter int NSRC = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt sources, level high
   input wire logic [NSRC-1:0] src,
   // core request lines, active low
   output logic normal_request_line_b,
   output logic fast_request_line_b,
   // protection mode state and block interrupt
   output logic protection_mode_bit,
   output logic irq
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [31:0] spurious_handler_vector;
   logic [1:0] debug_control;
   logic [31:0] fast_forcing;
   logic [31:0] enabled;
   logic [31:0] vec_mem [0:NSRC-1];
   logic [4:0] cur_id;
   logic cur_valid;
   logic [ICAUX_EVW-1:0] ev_stat;
   logic [ICAUX_EVW-1:0] ev_mask;
   icaux_req_s rq;

   assign rq = '{sel: psel, en: penable, wr: pwrite, addr: paddr,
                 wdata: pwdata};

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // no wait state: the access phase is always ready
   wire acc = rq.sel & rq.en;
   wire wr_acc = acc & rq.wr;
   wire rd_acc = acc & ~rq.wr;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   wire vec_hit = (rq.addr >= ICAUX_OFF_VEC_BASE) &&
                  (rq.addr[1:0] == 2'h0);
   wire [4:0] vec_idx = rq.addr[6:2];
   wire known = hit(rq.addr, ICAUX_OFF_VECTOR) |
                hit(rq.addr, ICAUX_OFF_FASTVEC) |
                hit(rq.addr, ICAUX_OFF_CUR_ID) |
                hit(rq.addr, ICAUX_OFF_PENDING) |
                hit(rq.addr, ICAUX_OFF_ENABLE) |
                hit(rq.addr, ICAUX_OFF_DISABLE) |
                hit(rq.addr, ICAUX_OFF_MASKRD) |
                hit(rq.addr, ICAUX_OFF_EOI) |
                hit(rq.addr, ICAUX_OFF_SPURIOUS) |
                hit(rq.addr, ICAUX_OFF_DEBUG) |
                hit(rq.addr, ICAUX_OFF_FF_EN) |
                hit(rq.addr, ICAUX_OFF_FF_DIS) |
                hit(rq.addr, ICAUX_OFF_FF_STATE) |
                hit(rq.addr, ICAUX_OFF_IRQ_STAT) |
                hit(rq.addr, ICAUX_OFF_IRQ_MASK) | vec_hit;

   wire wr_eoi = wr_acc & hit(rq.addr, ICAUX_OFF_EOI);
   wire wr_spur = wr_acc & hit(rq.addr, ICAUX_OFF_SPURIOUS);
   wire wr_debug = wr_acc & hit(rq.addr, ICAUX_OFF_DEBUG);
   wire wr_ffe = wr_acc & hit(rq.addr, ICAUX_OFF_FF_EN);
   wire wr_ffd = wr_acc & hit(rq.addr, ICAUX_OFF_FF_DIS);
   wire wr_ien = wr_acc & hit(rq.addr, ICAUX_OFF_ENABLE);
   wire wr_idis = wr_acc & hit(rq.addr, ICAUX_OFF_DISABLE);
   wire wr_ist = wr_acc & hit(rq.addr, ICAUX_OFF_IRQ_STAT);
   wire wr_imk = wr_acc & hit(rq.addr, ICAUX_OFF_IRQ_MASK);
   wire wr_vec = wr_acc & vec_hit;

   // ----------------------------------------------------------------
   // source routing
   // ----------------------------------------------------------------
   wire [31:0] active = 32'(src) & enabled;
   wire [31:0] fast_set = active & (fast_forcing |
                          (32'h1 << ICAUX_FAST_SRC));
   wire [31:0] norm_set = active & ~fast_set;
   wire fast_any = |fast_set;
   wire norm_any;
   wire [4:0] norm_id;

   icaux_arb #(.N(32)) u_arb (
      .req(norm_set),
      .any(norm_any),
      .id(norm_id)
   );

   wire rd_vector = rd_acc & hit(rq.addr, ICAUX_OFF_VECTOR);
   wire rd_fastvec = rd_acc & hit(rq.addr, ICAUX_OFF_FASTVEC);
   // a spurious read: nothing to serve when the vector is fetched
   wire spur_norm = rd_vector & ~norm_any & ~cur_valid;
   wire spur_fast = rd_fastvec & ~fast_any;
   // protection mode: reading the vector does not take the source
   wire take = rd_vector & norm_any & ~cur_valid &
               ~debug_control[ICAUX_PROTECTION_BIT];
   // under protection, software commits with a vector write
   wire protect_take = wr_acc & hit(rq.addr, ICAUX_OFF_VECTOR) &
                       norm_any & ~cur_valid &
                       debug_control[ICAUX_PROTECTION_BIT];

   wire [31:0] vec_rd = cur_valid ? vec_mem[cur_id] :
                        norm_any ? vec_mem[norm_id] :
                        spurious_handler_vector;
   wire [31:0] fvec_rd = fast_any ? vec_mem[ICAUX_FAST_SRC] :
                         spurious_handler_vector;

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0;
      case (1'b1)
         hit(rq.addr, ICAUX_OFF_VECTOR): next_rdata = vec_rd;
         hit(rq.addr, ICAUX_OFF_FASTVEC): next_rdata = fvec_rd;
         hit(rq.addr, ICAUX_OFF_CUR_ID): next_rdata = {27'h0, cur_id};
         hit(rq.addr, ICAUX_OFF_PENDING): next_rdata = 32'(src);
         hit(rq.addr, ICAUX_OFF_MASKRD): next_rdata = enabled;
         hit(rq.addr, ICAUX_OFF_SPURIOUS):
            next_rdata = spurious_handler_vector;
         hit(rq.addr, ICAUX_OFF_DEBUG): next_rdata = {30'h0, debug_control};
         hit(rq.addr, ICAUX_OFF_FF_STATE): next_rdata = fast_forcing;
         hit(rq.addr, ICAUX_OFF_IRQ_STAT): next_rdata = {30'h0, ev_stat};
         hit(rq.addr, ICAUX_OFF_IRQ_MASK): next_rdata = {30'h0, ev_mask};
         vec_hit: next_rdata = vec_mem[vec_idx];
         default: next_rdata = 32'h0;
      endcase
   end

   // ----------------------------------------------------------------
   // apb answer registers
   // ----------------------------------------------------------------
   // pready rises at the edge that ends the setup cycle so the access phase ends at once
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= rq.sel & ~rq.en;
         pslverr <= rq.sel & ~rq.en & ~known;
         if (rq.sel & ~rq.en & ~rq.wr) begin
            prdata <= next_rdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   // spurious and debug store
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         spurious_handler_vector <= ICAUX_SPUR_RESET;
         debug_control <= ICAUX_DEBUG_RESET;
      end else begin
         if (wr_spur) begin
            spurious_handler_vector <= rq.wdata;
         end
         if (wr_debug) begin
            debug_control <= rq.wdata[1:0];
         end
      end
   end

   // set forcing, clear forcing, bit 0 stays zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fast_forcing <= ICAUX_FF_RESET;
      end else begin
         fast_forcing <= ((fast_forcing |
                         ({32{wr_ffe}} & rq.wdata)) &
                         ~({32{wr_ffd}} & rq.wdata)) &
                         ~(32'h1 << ICAUX_FAST_SRC);
      end
   end

   // source enable set and clear commands
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         enabled <= 32'h0;
      end else begin
         enabled <= (enabled | ({32{wr_ien}} & rq.wdata)) &
                    ~({32{wr_idis}} & rq.wdata);
      end
   end

   // vector table has no reset, it is plain storage
   always_ff @(posedge clk) begin
      if (wr_vec) begin
         vec_mem[vec_idx] <= rq.wdata;
      end
   end

   // ----------------------------------------------------------------
   // current interrupt tracking
   // ----------------------------------------------------------------
   // eoi releases current; a new take in same cycle cannot occur
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cur_valid <= 1'b0;
         cur_id <= 5'h0;
      end else if (wr_eoi) begin
         cur_valid <= 1'b0;
      end else if (take | protect_take) begin
         cur_valid <= 1'b1;
         cur_id <= norm_id;
      end
   end

   // ----------------------------------------------------------------
   // request lines
   // ----------------------------------------------------------------
   // normal line asks while a source waits and none is being served
   // global mask holds lines high
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         normal_request_line_b <= 1'b1;
         fast_request_line_b <= 1'b1;
         protection_mode_bit <= 1'b0;
      end else begin
         normal_request_line_b <= ~(norm_any & ~cur_valid &
                                  ~debug_control[ICAUX_LINE_MASK_BIT]);
         fast_request_line_b <= ~(fast_any &
                                ~debug_control[ICAUX_LINE_MASK_BIT]);
         protection_mode_bit <= debug_control[ICAUX_PROTECTION_BIT];
      end
   end

   // ----------------------------------------------------------------
   // block interrupt: sticky events, write one to clear
   // ----------------------------------------------------------------
   wire [ICAUX_EVW-1:0] ev_in = {spur_norm | spur_fast, wr_eoi};
   // set wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ev_stat <= '0;
         ev_mask <= '0;
         irq <= 1'b0;
      end else begin
         ev_stat <= (ev_stat & ~({ICAUX_EVW{wr_ist}} &
                    rq.wdata[ICAUX_EVW-1:0])) | ev_in;
         if (wr_imk) begin
            ev_mask <= rq.wdata[ICAUX_EVW-1:0];
         end
         irq <= |(ev_stat & ev_mask);
      end
   end

endmodule : icaux_top

/* tb/icaux_core_model.sv */
// core model: takes both request lines as the processor would
// assumes active low lines synchronous to clk
module icaux_core_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // request lines from the controller
   input wire logic normal_request_line_b,
   input wire logic fast_request_line_b,
   // entries seen, sticky until reset
   output logic normal_taken,
   output logic fast_taken
);
   timeunit 1ns;
   timeprecision 1ps;
   // entry per line
   // sticky, so a short assertion of either line is not lost
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         normal_taken <= 1'b0;
         fast_taken <= 1'b0;
      end else begin
         normal_taken <= normal_taken | !normal_request_line_b;
         fast_taken <= fast_taken | !fast_request_line_b;
      end
   end
endmodule : icaux_core_model

/* tb/icaux_props.sv */
// checker: apb timing, register mirrors and line masking
// assumes binding to icaux_top; mirrors only writes that land
module icaux_props
   import icaux_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // core side
   input wire logic normal_request_line_b,
   input wire logic fast_request_line_b,
   input wire logic protection_mode_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // mirrors of the spurious, debug and forcing registers
   // ----------------------------------------------------------------
   logic [31:0] spur_q;
   logic [31:0] ff_q;
   logic [1:0] debug_q;
   wire done = psel && penable && pready && !pslverr;
   wire wr_ok = done && pwrite;
   wire rd_ok = done && !pwrite;
   // bit 0 can never be forced, so it is dropped on the way in
   wire [31:0] ff_set = pwdata & 32'hFFFF_FFFE;
   // refused transfers leave the mirrors alone
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         spur_q <= ICAUX_SPUR_RESET;
         debug_q <= ICAUX_DEBUG_RESET;
         ff_q <= ICAUX_FF_RESET;
      end else if (wr_ok) begin
         if (paddr == ICAUX_OFF_SPURIOUS) spur_q <= pwdata;
         if (paddr == ICAUX_OFF_DEBUG) debug_q <= pwdata[1:0];
         if (paddr == ICAUX_OFF_FF_EN) ff_q <= ff_q | ff_set;
         if (paddr == ICAUX_OFF_FF_DIS) ff_q <= ff_q & ~pwdata;
      end
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   a_ready_setup: assert property (setup_s ##1 access_s |-> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held");
   a_idle_quiet: assert property (!psel |=> !pready && !pslverr)
      else $error("answer without request");
   a_unmapped_err: assert property (
      access_s ##0 pready && paddr inside {[8'h3C:8'h7F]} |-> pslverr)
      else $error("unmapped not refused");
   a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read data");
   a_spur_read: assert property (
      rd_ok && paddr == ICAUX_OFF_SPURIOUS |-> prdata == spur_q)
      else $error("spurious vector readback");
   a_ffstate_read: assert property (
      rd_ok && paddr == ICAUX_OFF_FF_STATE |-> prdata == ff_q)
      else $error("forcing state readback");
   a_debug_read: assert property (
      rd_ok && paddr == ICAUX_OFF_DEBUG |-> prdata[1:0] == debug_q)
      else $error("debug readback");
   a_mask_lines: assert property (
      debug_q[1] |=> normal_request_line_b && fast_request_line_b)
      else $error("line active under mask");
   a_mode_copy: assert property (
      protection_mode_bit == $past(debug_q[0]))
      else $error("protection output");
endmodule : icaux_props

bind icaux_top icaux_props u_props (.clk(clk), .rst_b(rst_b),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .normal_request_line_b(normal_request_line_b),
   .fast_request_line_b(fast_request_line_b),
   .protection_mode_bit(protection_mode_bit));

/* tb/icaux_top_test.sv */
// bench: apb register sequences against icaux_top and a core model
// assumes one 25 MHz clock and the offsets of icaux_pkg
module icaux_top_test
   import icaux_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] src = 32'h0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr, nrl_b, frl_b, pmode, irq, n_tk, f_tk;
   int num_errors = 0;
   int num_checks = 0;
   always #20 clk = ~clk;
   icaux_top #(.NSRC(32)) dut (.clk(clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src(src), .normal_request_line_b(nrl_b),
      .fast_request_line_b(frl_b), .protection_mode_bit(pmode),
      .irq(irq));
   icaux_core_model core (.clk(clk), .rst_b(rst_b),
      .normal_request_line_b(nrl_b), .fast_request_line_b(frl_b),
      .normal_taken(n_tk), .fast_taken(f_tk));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer; request held until ready is seen at an edge
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, pready, 1'b1);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask : rd
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask : tick
   task automatic print_verdict;
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   // ----------------------------------------------------------------
   // sequence of tests
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      chk({31'h0, pmode}, 32'h0);
      rd(ICAUX_OFF_SPURIOUS, 32'h0);
      rd(ICAUX_OFF_DEBUG, 32'h0);
      rd(ICAUX_OFF_FF_STATE, 32'h0);
      wr(ICAUX_OFF_SPURIOUS, 32'hA5A5_5A5A);
      rd(ICAUX_OFF_SPURIOUS, 32'hA5A5_5A5A);
      rd(ICAUX_OFF_VECTOR, 32'hA5A5_5A5A);
      rd(ICAUX_OFF_FASTVEC, 32'hA5A5_5A5A);
      rd(ICAUX_OFF_IRQ_STAT, 32'h2);
      chk({31'h0, irq}, 32'h0);
      wr(ICAUX_OFF_IRQ_MASK, 32'h2);
      tick(2);
      chk({31'h0, irq}, 32'h1);
      wr(ICAUX_OFF_IRQ_STAT, 32'h2);
      tick(2);
      chk({31'h0, irq}, 32'h0);
      // forcing set and clear; zeros and read-only writes change nothing
      wr(ICAUX_OFF_FF_EN, 32'hFFFF_FFFF);
      rd(ICAUX_OFF_FF_STATE, 32'hFFFF_FFFE);
      wr(ICAUX_OFF_FF_DIS, 32'h0000_00F1);
      wr(ICAUX_OFF_FF_EN, 32'h0);
      wr(ICAUX_OFF_FF_DIS, 32'h0);
      wr(ICAUX_OFF_FF_STATE, 32'h0);
      rd(ICAUX_OFF_FF_STATE, 32'hFFFF_FF0E);
      // a forced source reaches only the fast line
      wr(ICAUX_OFF_ENABLE, 32'h20);
      wr(ICAUX_OFF_FF_EN, 32'h20);
      src <= 32'h20;
      tick(4);
      chk({30'h0, nrl_b, frl_b}, 32'h2);
      chk({30'h0, n_tk, f_tk}, 32'h1);
      wr(ICAUX_OFF_DEBUG, 32'h2);
      tick(2);
      chk({30'h0, nrl_b, frl_b}, 32'h3);
      rd(ICAUX_OFF_DEBUG, 32'h2);
      wr(ICAUX_OFF_DEBUG, 32'h1);
      tick(2);
      chk({31'h0, pmode}, 32'h1);
      wr(ICAUX_OFF_DEBUG, 32'h0);
      // unforced again: normal vectoring of source 5
      wr(ICAUX_OFF_FF_DIS, 32'h20);
      tick(4);
      chk({30'h0, nrl_b, frl_b}, 32'h1);
      wr(ICAUX_OFF_VEC_BASE + 8'h14, 32'h0000_1234);
      rd(ICAUX_OFF_VECTOR, 32'h0000_1234);
      rd(ICAUX_OFF_CUR_ID, 32'h5);
      wr(ICAUX_OFF_EOI, 32'hDEAD_BEEF);
      rd(ICAUX_OFF_IRQ_STAT, 32'h1);
      wr(ICAUX_OFF_IRQ_MASK, 32'h1);
      tick(2);
      chk({31'h0, irq}, 32'h1);
      wr(ICAUX_OFF_IRQ_STAT, 32'h1);
      tick(2);
      chk({31'h0, irq}, 32'h0);
      // protection: a vector read takes nothing, a vector write commits
      wr(ICAUX_OFF_DEBUG, 32'h1);
      rd(ICAUX_OFF_VECTOR, 32'h0000_1234);
      chk({30'h0, nrl_b, frl_b}, 32'h1);
      wr(ICAUX_OFF_VECTOR, 32'h0);
      tick(2);
      chk({30'h0, nrl_b, frl_b}, 32'h3);
      wr(ICAUX_OFF_EOI, 32'h0);
      tick(2);
      chk({30'h0, nrl_b, frl_b}, 32'h1);
      wr(ICAUX_OFF_DEBUG, 32'h0);
      // unmapped place is refused with zero data
      xfer(1'b0, 8'h40, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      chk(rdat, 32'h0);
      print_verdict();
   end
   // watchdog: about seven times the expected run
   initial begin
      #40000;
      num_errors++;
      print_verdict();
   end
endmodule : icaux_top_test
